// >>> sec_asserts.sv
// Purpose: port checks for the equalizer register bank
// Assumes: ce stays high while a transfer is in flight
// Notes: lanes 0, 3 and 15 stand for all lanes to keep the checker small
`timescale 1ns/10ps
`default_nettype none
module sec_asserts (
   input wire logic hclk, // bus clock
   input wire logic hresetn, // async reset, active low
   input wire logic ce, // clock enable
   input wire logic hsel, // slave select
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write when high
   input wire logic hready, // bus ready in
   input wire logic hreadyout, // slave ready out
   input wire logic hresp, // response
   input wire logic [31:0] hrdata, // read data
   input wire sec_pkg::sec_lane_ctrl_type lane_ctrl [sec_pkg::SEC_LANES] // ctl
);
   import sec_pkg::*;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire logic take = ce && hsel && hready && htrans[1];
   resp_okay_a: assert property (hresp == SEC_HRESP_OKAY)
      else $error("response not okay");
   rd_wait_a: assert property
      (take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   wr_nowait_a: assert property (take && hwrite |=> hreadyout)
      else $error("write stalled");
   ce_stall_a: assert property (!ce |-> !hreadyout)
      else $error("ready while clock disabled");
   rsvd_zero_a: assert property (hrdata[31:8] == 24'h0)
      else $error("upper read data not zero");
   manual_mode_a: assert property
      (lane_ctrl[0].level_from_manual |->
      lane_ctrl[0].mode == SEC_MODE_ADAPT)
      else $error("manual level outside adaptive mode");
   hold_mode_a: assert property
      (lane_ctrl[0].adapt_hold |->
      lane_ctrl[0].mode == SEC_MODE_ADAPT &&
      !lane_ctrl[0].level_from_manual)
      else $error("freeze outside fully adaptive mode");
   boost_db_a: assert property
      (lane_ctrl[3].boost_db == {lane_ctrl[3].gain_boost_sel, 1'b0})
      else $error("boost step wrong");
   all_lanes_a: assert property
      (lane_ctrl[0].mode == lane_ctrl[15].mode &&
      lane_ctrl[0].zero_freq_code == lane_ctrl[15].zero_freq_code)
      else $error("lanes disagree on shared settings");
endmodule
bind sec_top sec_asserts i_chk (.hclk(hclk), .hresetn(hresetn), .ce(ce),
   .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .lane_ctrl(lane_ctrl));
`default_nettype wire

// >>> sec_lane.sv
// Purpose: one lane's setting register, control word and status byte
// Assumes: status inputs synchronous to hclk
// Notes:   control word registered so the analog side sees flops
`timescale 1ns/10ps
`default_nettype none
module sec_lane (
   input wire logic hclk, // bus clock
   input wire logic hresetn, // async reset, active low
   input wire logic ce, // clock enable
   input wire logic wr_en, // write this lane's setting
   input wire logic [7:0] wdata, // write byte
   input wire logic [7:0] global_ctrl, // global control register
   input wire logic [4:0] zero_code, // zero code in force
   input wire sec_pkg::sec_lane_stat_type stat_in, // lane analog status
   output sec_pkg::sec_lane_ctrl_type ctrl_out, // lane control word
   output logic [7:0] setting_rb, // setting readback
   output logic [7:0] status_rb // status readback
);
   import sec_pkg::*;

   logic [7:0] setting_r;
   sec_lane_ctrl_type ctrl_nxt;
   sec_mode_type mode;
   logic lovr;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         setting_r <= SEC_LANE_SET_RST;
      end else if (ce && wr_en) begin
         setting_r <= wdata & SEC_LANE_SET_MASK;
      end
   end

   always_comb begin
      mode = sec_mode_type'(global_ctrl[SEC_MODE_LSB +: 2]);
      lovr = global_ctrl[SEC_LOVR_BIT];
      ctrl_nxt.mode = mode;
      ctrl_nxt.level_from_manual = (mode == SEC_MODE_ADAPT) && lovr;
      ctrl_nxt.adapt_hold = (mode == SEC_MODE_ADAPT) && !lovr &&
                            global_ctrl[SEC_FREEZE_BIT];
      ctrl_nxt.manual_level = setting_r[4:0];
      ctrl_nxt.gain_boost_sel = setting_r[SEC_BOOST_LSB +: 2];
      ctrl_nxt.boost_db = sec_boost_db(setting_r[SEC_BOOST_LSB +: 2]);
      ctrl_nxt.zero_freq_code = zero_code;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_out <= '0;
      end else if (ce) begin
         ctrl_out <= ctrl_nxt;
      end
   end

   assign setting_rb = setting_r;

   // pure wiring: a read never touches the lane's flags
   always_comb begin
      status_rb = 8'h00;
      status_rb[SEC_OVER_BIT] = stat_in.analysis_over_flag;
      status_rb[SEC_UNDER_BIT] = stat_in.analysis_under_flag;
      status_rb[4:0] = sec_popcount(stat_in.therm_level);
   end
endmodule
`default_nettype wire

// >>> sec_lane_model.sv
// Purpose: far-side lane model giving each lane's analysis status
// Assumes: levels 0 to 16 from the bench
// Notes: thermometer code fills from bit 0 upward
`timescale 1ns/10ps
`default_nettype none
module sec_lane_model (
   input wire logic [4:0] lvl [sec_pkg::SEC_LANES], // level per lane
   input wire logic [15:0] ovr, // over flags
   input wire logic [15:0] und, // under flags
   output var sec_pkg::sec_lane_stat_type lane_stat [sec_pkg::SEC_LANES] // out
);
   import sec_pkg::*;
   always_comb begin
      for (int i = 0; i < SEC_LANES; i++) begin
         lane_stat[i].therm_level = 16'((17'h1 << lvl[i]) - 17'h1);
         lane_stat[i].analysis_over_flag = ovr[i];
         lane_stat[i].analysis_under_flag = und[i];
      end
   end
endmodule
`default_nettype wire

// >>> sec_pkg.sv
// Purpose: shared constants, types and decode helpers for the
//          serial receive equalizer control block
// Assumes: 32-bit AHB-Lite data, one register per aligned word
// Notes:   byte address of a register is four times its index
`default_nettype none
package sec_pkg;

   localparam int SEC_LANES = 16;

   // register indices; byte address = index * 4
   localparam logic [9:0] SEC_IDX_GLOBAL = 10'h1c2;
   localparam logic [9:0] SEC_IDX_ZERO = 10'h1c3;
   localparam logic [9:0] SEC_IDX_LANE_SET = 10'h1d0;
   localparam logic [9:0] SEC_IDX_LANE_STAT = 10'h1e0;

   // global control field positions and register write masks
   localparam int SEC_MODE_LSB = 0;
   localparam int SEC_FREEZE_BIT = 2;
   localparam int SEC_ZOVR_BIT = 3;
   localparam int SEC_LOVR_BIT = 4;
   localparam logic [7:0] SEC_GLOBAL_MASK = 8'h1f;
   localparam logic [7:0] SEC_ZERO_MASK = 8'h1f;
   localparam logic [7:0] SEC_LANE_SET_MASK = 8'h7f;

   // lane setting and status field positions
   localparam int SEC_BOOST_LSB = 5;
   localparam int SEC_OVER_BIT = 6;
   localparam int SEC_UNDER_BIT = 5;

   // reset values
   localparam logic [7:0] SEC_GLOBAL_RST = 8'h00;
   localparam logic [7:0] SEC_ZERO_RST = 8'h00;
   localparam logic [7:0] SEC_LANE_SET_RST = 8'h08;

   // lane rate codes and automatic zero codes
   localparam logic [1:0] SEC_RATE_FULL = 2'h0;
   localparam logic [1:0] SEC_RATE_HALF = 2'h1;
   localparam logic [1:0] SEC_RATE_QUARTER = 2'h2;
   localparam logic [1:0] SEC_RATE_EIGHTH = 2'h3;
   localparam logic [4:0] SEC_ZAUTO_FULL = 5'h1f;
   localparam logic [4:0] SEC_ZAUTO_QUARTER = 5'h1b;
   localparam logic [4:0] SEC_ZAUTO_EIGHTH = 5'h08;

   // ahb-lite codes
   localparam logic [1:0] SEC_HTRANS_NONSEQ = 2'h2;
   localparam logic SEC_HRESP_OKAY = 1'b0;

   typedef enum logic [1:0] {
      SEC_MODE_OFF = 2'h0,
      SEC_MODE_ADAPT = 2'h1,
      SEC_MODE_PRE = 2'h2,
      SEC_MODE_POST = 2'h3
   } sec_mode_type;

   typedef enum logic [3:0] {
      SEC_BUS_IDLE = 4'h1,
      SEC_BUS_WRITE = 4'h2,
      SEC_BUS_RD_WAIT = 4'h4,
      SEC_BUS_RD_DONE = 4'h8
   } sec_bus_state_type;

   typedef struct packed {
      sec_mode_type mode;
      logic level_from_manual;
      logic adapt_hold;
      logic [4:0] manual_level;
      logic [1:0] gain_boost_sel;
      logic [2:0] boost_db;
      logic [4:0] zero_freq_code;
   } sec_lane_ctrl_type;

   typedef struct packed {
      logic [15:0] therm_level;
      logic analysis_over_flag;
      logic analysis_under_flag;
   } sec_lane_stat_type;

   function automatic logic [4:0] sec_popcount(input logic [15:0] therm);
      logic [4:0] cnt;
      cnt = 5'h00;
      for (int i = 0; i < 16; i++) begin
         cnt = cnt + {4'h0, therm[i]};
      end
      return cnt;
   endfunction

   function automatic logic [4:0] sec_auto_zero(input logic [1:0] rate);
      logic [4:0] z;
      unique case (rate)
         SEC_RATE_FULL, SEC_RATE_HALF: z = SEC_ZAUTO_FULL;
         SEC_RATE_QUARTER: z = SEC_ZAUTO_QUARTER;
         SEC_RATE_EIGHTH: z = SEC_ZAUTO_EIGHTH;
      endcase
      return z;
   endfunction

   // boost step in dB: two per code step
   function automatic logic [2:0] sec_boost_db(input logic [1:0] code);
      return {code, 1'b0};
   endfunction

   function automatic logic sec_in_bank(input logic [9:0] idx,
                                        input logic [9:0] base);
      return idx[9:4] == base[9:4];
   endfunction

endpackage
`default_nettype wire

// >>> sec_top.sv
// Purpose: ahb-lite register bank for the receive equalizer of a
//          sixteen-lane serial receiver
// Assumes: single word transfers only, one slave on the bus
// Notes:   writes take no wait state, reads take one
// Summary of operation
// - adaptive mode with level override takes each lane's manual level
// - zero override applies programmed code, else code follows lane rate
// - freeze holds adaptation only in adaptive mode without override
// - two-bit mode: off, adaptive, precursor or postcursor analysis
// - automatic zero code: 1f full/half, 1b quarter, 08 eighth rate
// - five-bit zero code in bits 4:0, shared by all lanes
// - sixteen lane setting registers consecutive from 1d0, lane 0 lowest
// - boost bits 6:5 add 0, 2, 4 or 6 dB gain
// - manual level used only under override; software keeps it 0 to 16
// - status bit 6 reports the lane's analysis over flag
// - status bit 5 reports the lane's analysis under flag
// - status low bits give count of set thermometer level bits
// - global control at 1c2 resets to zero, equalizer disabled
// - status registers from 1e0 are read-only and ignore writes
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module sec_top (
   input wire logic hclk, // bus clock, 10 MHz
   input wire logic hresetn, // async reset, active low
   input wire logic ce, // clock enable, freezes all state
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write when high
   input wire logic [2:0] hsize, // transfer size, word assumed
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready in
   output logic hreadyout, // slave ready out
   output logic hresp, // response, always okay
   output logic [31:0] hrdata, // read data
   input wire logic [1:0] lane_rate, // lane rate setting
   input wire sec_pkg::sec_lane_stat_type lane_stat [sec_pkg::SEC_LANES], // in
   output sec_pkg::sec_lane_ctrl_type lane_ctrl [sec_pkg::SEC_LANES] // out
);
   import sec_pkg::*;

   sec_bus_state_type state_r;
   sec_bus_state_type state_nxt;
   logic [7:0] global_r;
   logic [7:0] zero_r;
   logic [4:0] zero_code_r;
   logic [4:0] zero_code_nxt;
   logic [9:0] idx_r;
   logic mapped_r;
   logic [31:0] hrdata_r;
   logic [7:0] rd_byte;
   logic take;
   logic addr_ok;
   logic wr_en;
   logic [7:0] wbyte;
   logic lane_set_wr;
   logic [7:0] set_rb [SEC_LANES];
   logic [7:0] stat_rb [SEC_LANES];

   // hsize is not decoded: only whole words are ever issued
   assign take = ce && hsel && hready && htrans[1];
   assign addr_ok = (haddr[31:12] == 20'h00000) && (haddr[1:0] == 2'h0);

   // data phase of a write completes only on an enabled cycle
   assign wr_en = ce && (state_r == SEC_BUS_WRITE) && mapped_r;
   assign wbyte = hwdata[7:0];

   // low ce stretches every data phase, so no beat is lost
   assign hreadyout = ce && (state_r != SEC_BUS_RD_WAIT);
   assign hresp = SEC_HRESP_OKAY;
   assign hrdata = hrdata_r;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         SEC_BUS_IDLE, SEC_BUS_WRITE, SEC_BUS_RD_DONE: begin
            if (take) begin
               state_nxt = hwrite ? SEC_BUS_WRITE : SEC_BUS_RD_WAIT;
            end else begin
               state_nxt = SEC_BUS_IDLE;
            end
         end
         SEC_BUS_RD_WAIT: begin
            state_nxt = SEC_BUS_RD_DONE;
         end
         default: begin
            state_nxt = SEC_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= SEC_BUS_IDLE;
      end else if (ce) begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         idx_r <= 10'h000;
         mapped_r <= 1'b0;
      end else if (take) begin
         idx_r <= haddr[11:2];
         mapped_r <= addr_ok;
      end
   end

   // reserved bits are dropped on write and read back as zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         global_r <= SEC_GLOBAL_RST;
      end else if (wr_en && (idx_r == SEC_IDX_GLOBAL)) begin
         global_r <= wbyte & SEC_GLOBAL_MASK;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         zero_r <= SEC_ZERO_RST;
      end else if (wr_en && (idx_r == SEC_IDX_ZERO)) begin
         zero_r <= wbyte & SEC_ZERO_MASK;
      end
   end

   // rate may move at any time, so the choice is re-made every cycle
   always_comb begin
      if (global_r[SEC_ZOVR_BIT]) begin
         zero_code_nxt = zero_r[4:0];
      end else begin
         zero_code_nxt = sec_auto_zero(lane_rate);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         zero_code_r <= SEC_ZAUTO_FULL;
      end else if (ce) begin
         zero_code_r <= zero_code_nxt;
      end
   end

   // status bank has no write path at all
   assign lane_set_wr = wr_en && sec_in_bank(idx_r, SEC_IDX_LANE_SET);

   for (genvar g = 0; g < SEC_LANES; g++) begin : g_lane
      sec_lane u_lane (
         .hclk(hclk),
         .hresetn(hresetn),
         .ce(ce),
         .wr_en(lane_set_wr && (idx_r[3:0] == 4'(g))),
         .wdata(wbyte),
         .global_ctrl(global_r),
         .zero_code(zero_code_r),
         .stat_in(lane_stat[g]),
         .ctrl_out(lane_ctrl[g]),
         .setting_rb(set_rb[g]),
         .status_rb(stat_rb[g])
      );
   end

   always_comb begin
      rd_byte = 8'h00;
      if (mapped_r) begin
         if (idx_r == SEC_IDX_GLOBAL) begin
            rd_byte = global_r;
         end else if (idx_r == SEC_IDX_ZERO) begin
            rd_byte = zero_r;
         end else if (sec_in_bank(idx_r, SEC_IDX_LANE_SET)) begin
            rd_byte = set_rb[idx_r[3:0]];
         end else if (sec_in_bank(idx_r, SEC_IDX_LANE_STAT)) begin
            rd_byte = stat_rb[idx_r[3:0]];
         end
      end
   end

   // the wait cycle lets a write in the overlapping beat land first
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_r <= 32'h00000000;
      end else if (ce && (state_r == SEC_BUS_RD_WAIT)) begin
         hrdata_r <= {24'h000000, rd_byte};
      end
   end
endmodule
`default_nettype wire

// >>> testbench.sv
// Purpose: self-checking bench for the equalizer register bank
// Assumes: hready looped from hreadyout, single slave
// Notes: read results checked by a monitor against a queue of notes
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import sec_pkg::*;
   logic hclk = 0, hresetn = 0, ce = 1, hsel = 0, hwrite = 0, rd_ph = 0;
   logic [31:0] haddr = 0, hwdata = 0, seed = 32'hb02ea612, v;
   logic [1:0] htrans = 0, lane_rate = 0;
   logic [2:0] hsize = 3'h2;
   logic [7:0] e;
   wire logic hreadyout, hresp;
   wire logic [31:0] hrdata;
   sec_lane_stat_type lane_stat [SEC_LANES];
   sec_lane_ctrl_type lane_ctrl [SEC_LANES];
   logic [4:0] lvl [SEC_LANES];
   logic [15:0] ovr = 0, und = 0;
   logic [7:0] setv [SEC_LANES];
   logic [31:0] expq [$];
   int errors = 0, n_tests = 0, cyc = 0;
   sec_top i_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .lane_rate(lane_rate),
      .lane_stat(lane_stat), .lane_ctrl(lane_ctrl));
   sec_lane_model i_far (.lvl(lvl), .ovr(ovr), .und(und),
      .lane_stat(lane_stat));
   initial forever #50 hclk = ~hclk;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("errors %0d comparisons %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic xfer(input logic [31:0] a, input logic w,
                       input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= SEC_HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] x);
      expq.push_back(x);
      xfer(a, 1'b0, 32'h0);
   endtask
   task automatic chk_ctrl(input logic [4:0] g, input int n);
      logic [4:0] zx;
      // zero override uses the programmed 0a, else rate picks the code
      zx = g[3] ? 5'h0a : (lane_rate[1] ? (lane_rate[0] ? 5'h08 : 5'h1b)
         : 5'h1f);
      check(32'(lane_ctrl[n].mode), 32'(g[1:0]));
      check(32'(lane_ctrl[n].level_from_manual),
         32'(g[1:0] == 2'h1 && g[4]));
      check(32'(lane_ctrl[n].adapt_hold),
         32'(g[1:0] == 2'h1 && g[2] && !g[4]));
      check(32'(lane_ctrl[n].zero_freq_code), 32'(zx));
      check(32'({lane_ctrl[n].gain_boost_sel, lane_ctrl[n].manual_level}),
         32'(setv[n][6:0]));
      check(32'(lane_ctrl[n].boost_db), 32'({setv[n][6:5], 1'b0}));
   endtask
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (rd_ph && hreadyout) check(hrdata, expq.pop_front());
      if (rd_ph && hreadyout) check(32'(hresp), 32'(SEC_HRESP_OKAY));
      if (hreadyout) rd_ph <= hsel && htrans[1] && !hwrite;
      if (cyc > 20000) begin
         errors++;
         finish_test();
      end
   end
   initial begin
      for (int i = 0; i < SEC_LANES; i++) lvl[i] = 5'h0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      rd(32'h708, 32'h0);
      rd(32'h70c, 32'h0);
      wr_zero: xfer(32'h70c, 1'b1, 32'hffffffea);
      rd(32'h70c, 32'h0a);
      for (int i = 0; i < SEC_LANES; i++) begin
         rd(32'(32'h740 + 4 * i), 32'h08);
         v = rnd();
         // manual level kept within 0 to 16, bit 7 written as junk
         setv[i] = {1'b0, v[6:5], 5'(v[15:8] % 17)};
         xfer(32'(32'h740 + 4 * i), 1'b1, {v[31:7], setv[i][6:0]});
         rd(32'(32'h740 + 4 * i), 32'(setv[i]));
      end
      for (int g = 0; g < 32; g++) begin
         lane_rate <= 2'(rnd());
         xfer(32'h708, 1'b1, 32'(g) | 32'he0);
         rd(32'h708, 32'(g));
         repeat (3) @(posedge hclk);
         chk_ctrl(5'(g), int'(rnd() % 16));
      end
      for (int i = 0; i < SEC_LANES; i++) begin
         v = rnd();
         e = {1'b0, v[6], v[5], 5'(v[15:8] % 17)};
         lvl[i] <= e[4:0];
         ovr[i] <= e[6];
         und[i] <= e[5];
         xfer(32'(32'h780 + 4 * i), 1'b1, ~v);
         rd(32'(32'h780 + 4 * i), 32'(e));
         rd(32'(32'h780 + 4 * i), 32'(e));
      end
      rd(32'h10000708, 32'h0);
      rd(32'h709, 32'h0);
      @(posedge hclk);
      ce <= 1'b0;
      repeat (3) @(posedge hclk);
      ce <= 1'b1;
      rd(32'h708, 32'h1f);
      repeat (3) @(posedge hclk);
      finish_test();
   end
endmodule
`default_nettype wire
